/* sspc_ctrl.sv */
// Script-driven control of an SPI master port: enable, disable, sample width
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Disable floats clock and data of port
// - Disable floats every chip select output
// - Enable drives port pins as master
// - Enable drives all chip selects high
// - Width command sets bits per sample
// - Width holds until script starts or ends, or changed
// - Commands act on port chosen at launch
module sspc_ctrl
  import sspc_pkg::*;
#(
  parameter int NPORT = SSPC_NUM_PORTS,
  parameter int NCS   = SSPC_NUM_CS,
  parameter int MAXW  = SSPC_MAX_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Script runner
  input  wire logic             script_start,
  input  wire logic             script_port,
  input  wire logic             script_end,
  input  wire logic             cmd_valid,
  input  wire logic [1:0]       cmd_code,
  input  wire logic [5:0]       cmd_bits,
  input  wire logic [MAXW-1:0]  cmd_wdata,
  input  wire logic [NCS-1:0]   cs_level,
  output logic                  cmd_ready,
  output logic                  cmd_done,
  output logic [MAXW-1:0]       cmd_rdata,
  output logic                  port_enabled,
  output logic [5:0]            bits_per_sample,
  // SPI pins, output enable low while driven
  output logic [NPORT-1:0]      sclk_o,
  output logic [NPORT-1:0]      sclk_oe_n,
  output logic [NPORT-1:0]      mosi_o,
  output logic [NPORT-1:0]      mosi_oe_n,
  input  wire logic [NPORT-1:0] miso_i,
  output logic [NCS-1:0]        cs_o,
  output logic [NCS-1:0]        cs_oe_n
);

  // ==========================================================================
  // State
  typedef struct packed {
    sspc_state_t    st;
    logic           port;
    logic           en;
    logic [5:0]     bits;
    logic [NCS-1:0] cs;
    logic           done;
    logic [MAXW-1:0] rdata;
  } sspc_ctrl_t;

  sspc_ctrl_t r_reg, r_next;

  logic [NPORT-1:0] miso_m_reg;
  logic [NPORT-1:0] miso_s_reg;
  logic             sh_start;
  logic             sh_busy;
  logic [MAXW-1:0]  sh_rx;
  logic             sh_sclk;
  logic             sh_mosi;
  logic             sh_busy_d_reg;

  // Two-flop synchroniser for the slave data pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      miso_m_reg    <= '0;
      miso_s_reg    <= '0;
      sh_busy_d_reg <= 1'b0;
    end else begin
      miso_m_reg    <= miso_i;
      miso_s_reg    <= miso_m_reg;
      sh_busy_d_reg <= sh_busy;
    end
  end

  // ==========================================================================
  // Command sequencer
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    sh_start    = 1'b0;
    unique case (r_reg.st)
      SSPC_IDLE: begin
        if (script_start) begin
          // Port latched once per script, commands carry none
          r_next.port = script_port;
          r_next.bits = SSPC_BITS_RESET;
        end else if (cmd_valid) begin
          r_next.st = SSPC_EXEC;
        end
      end
      SSPC_EXEC: begin
        unique case (cmd_code)
          SSPC_CMD_DISABLE: begin
            r_next.en = 1'b0;
            r_next.st = SSPC_DONE;
          end
          SSPC_CMD_ENABLE: begin
            r_next.en = 1'b1;
            r_next.cs = '1;
            r_next.st = SSPC_DONE;
          end
          SSPC_CMD_BITS: begin
            // Out-of-range widths are clamped rather than rejected
            if (cmd_bits < SSPC_BITS_MIN) begin
              r_next.bits = SSPC_BITS_MIN;
            end else if (cmd_bits > 6'(MAXW)) begin
              r_next.bits = 6'(MAXW);
            end else begin
              r_next.bits = cmd_bits;
            end
            r_next.st = SSPC_DONE;
          end
          SSPC_CMD_XFER: begin
            r_next.cs = cs_level;
            if (r_reg.en) begin
              sh_start  = 1'b1;
              r_next.st = SSPC_SHFT;
            end else begin
              r_next.st = SSPC_DONE;
            end
          end
        endcase
      end
      SSPC_SHFT: begin
        if (sh_busy_d_reg && !sh_busy) begin
          r_next.rdata = sh_rx;
          r_next.st    = SSPC_DONE;
        end
      end
      SSPC_DONE: begin
        r_next.done = 1'b1;
        r_next.st   = SSPC_IDLE;
      end
      default: r_next.st = SSPC_IDLE;
    endcase
    if (script_end && r_reg.st == SSPC_IDLE) begin
      // Width persists only for the running script
      r_next.bits = SSPC_BITS_RESET;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_reg      <= '0;
      r_reg.st   <= SSPC_IDLE;
      r_reg.bits <= SSPC_BITS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  sspc_shifter #(
    .MAXW (MAXW),
    .HALF (SSPC_HALF_CYC)
  ) u_shift (
    .clk       (clk),
    .reset     (reset),
    .start     (sh_start),
    .nbits     (r_reg.bits),
    .tx_data   (cmd_wdata),
    .busy      (sh_busy),
    .rx_data   (sh_rx),
    .sclk      (sh_sclk),
    .mosi      (sh_mosi),
    .miso_sync (miso_s_reg[r_reg.port])
  );

  // ==========================================================================
  // Pin drive
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign sclk_o[gp]    = (r_reg.port == 1'(gp)) ? sh_sclk : 1'b0;
      assign mosi_o[gp]    = (r_reg.port == 1'(gp)) ? sh_mosi : 1'b0;
      // Only the launched port is driven, and only while enabled
      assign sclk_oe_n[gp] = ~(r_reg.en && r_reg.port == 1'(gp));
      assign mosi_oe_n[gp] = ~(r_reg.en && r_reg.port == 1'(gp));
    end
  endgenerate

  assign cs_o            = r_reg.cs;
  assign cs_oe_n         = {NCS{~r_reg.en}};
  assign cmd_ready       = (r_reg.st == SSPC_IDLE) && !script_start;
  assign cmd_done        = r_reg.done;
  assign cmd_rdata       = r_reg.rdata;
  assign port_enabled    = r_reg.en;
  assign bits_per_sample = r_reg.bits;

  // ==========================================================================
  // Checks
  a_disable_floats: assert property (@(posedge clk) disable iff (reset)
    (r_reg.st == SSPC_EXEC && cmd_code == SSPC_CMD_DISABLE) |=>
      (cs_oe_n == '1 && sclk_oe_n == '1 && mosi_oe_n == '1))
    else $error("disable left pins driven");
  a_disable_cs: assert property (@(posedge clk) disable iff (reset)
    !port_enabled |-> cs_oe_n == '1)
    else $error("chip select driven while disabled");
  a_enable_drive: assert property (@(posedge clk) disable iff (reset)
    (r_reg.st == SSPC_EXEC && cmd_code == SSPC_CMD_ENABLE) |=>
      (sclk_oe_n[r_reg.port] == 1'b0 && mosi_oe_n[r_reg.port] == 1'b0))
    else $error("enable did not drive port");
  a_enable_cs: assert property (@(posedge clk) disable iff (reset)
    (r_reg.st == SSPC_EXEC && cmd_code == SSPC_CMD_ENABLE) |=>
      (cs_o == '1 && cs_oe_n == '0))
    else $error("enable did not drive selects high");
  a_bits_set: assert property (@(posedge clk) disable iff (reset)
    (r_reg.st == SSPC_EXEC && cmd_code == SSPC_CMD_BITS && cmd_bits >= SSPC_BITS_MIN &&
     cmd_bits <= 6'(MAXW)) |=> bits_per_sample == $past(cmd_bits))
    else $error("width not taken");
  a_bits_hold: assert property (@(posedge clk) disable iff (reset)
    (!$past(script_start) && !$past(script_end) &&
     !($past(r_reg.st) == SSPC_EXEC && $past(cmd_code) == SSPC_CMD_BITS))
      |-> $stable(bits_per_sample))
    else $error("width changed without command");
  a_port_stable: assert property (@(posedge clk) disable iff (reset)
    (r_reg.st != SSPC_IDLE) |=> $stable(r_reg.port))
    else $error("port changed during command");
  a_one_at_time: assert property (@(posedge clk) disable iff (reset)
    cmd_done |-> ##1 !cmd_done)
    else $error("done repeated");

endmodule : sspc_ctrl
`default_nettype wire

/* sspc_pkg.sv */
// Constants and types for the SPI master port script control
`default_nettype none
package sspc_pkg;

  // ==========================================================================
  // Script command codes
  localparam logic [1:0] SSPC_CMD_DISABLE = 2'h0;
  localparam logic [1:0] SSPC_CMD_ENABLE  = 2'h1;
  localparam logic [1:0] SSPC_CMD_BITS    = 2'h2;
  localparam logic [1:0] SSPC_CMD_XFER    = 2'h3;

  // ==========================================================================
  // Sizes and reset values
  localparam int          SSPC_NUM_PORTS   = 2;
  localparam int          SSPC_NUM_CS      = 4;
  localparam int          SSPC_MAX_BITS    = 32;
  localparam logic [5:0]  SSPC_BITS_RESET  = 6'h08;
  localparam logic [5:0]  SSPC_BITS_MIN    = 6'h04;
  localparam int          SSPC_CLK_HZ      = 20000000;
  localparam int          SSPC_SCLK_HZ     = 1000000;
  // Half period of the serial clock, longest time rounded down
  localparam int          SSPC_HALF_CYC    = (SSPC_CLK_HZ / SSPC_SCLK_HZ) / 2;

  // ==========================================================================
  // Controller states
  typedef enum logic [3:0] {
    SSPC_IDLE = 4'b0001,
    SSPC_EXEC = 4'b0010,
    SSPC_SHFT = 4'b0100,
    SSPC_DONE = 4'b1000
  } sspc_state_t;

endpackage : sspc_pkg
`default_nettype wire

/* sspc_shifter.sv */
// Serial shifter that clocks one sample of programmable width
`timescale 1ns/1ps
`default_nettype none
module sspc_shifter
  import sspc_pkg::*;
#(
  parameter int MAXW = SSPC_MAX_BITS,
  parameter int HALF = SSPC_HALF_CYC
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // Control
  input  wire logic            start,
  input  wire logic [5:0]      nbits,
  input  wire logic [MAXW-1:0] tx_data,
  output logic                 busy,
  output logic [MAXW-1:0]      rx_data,
  // Serial side
  output logic                 sclk,
  output logic                 mosi,
  input  wire logic            miso_sync
);

  typedef struct packed {
    logic            busy;
    logic            sclk;
    logic [5:0]      left;
    logic [7:0]      div;
    logic [MAXW-1:0] sh;
    logic [MAXW-1:0] rx;
  } sspc_sh_t;

  sspc_sh_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (!s_reg.busy) begin
      if (start) begin
        s_next.busy = 1'b1;
        s_next.left = nbits;
        s_next.div  = 8'h00;
        // Left-justify so the MSB of the sample goes first
        s_next.sh   = tx_data << (6'(MAXW) - nbits);
        s_next.rx   = '0;
      end
    end else if (s_reg.div == 8'(HALF - 1)) begin
      s_next.div  = 8'h00;
      s_next.sclk = ~s_reg.sclk;
      if (!s_reg.sclk) begin
        s_next.rx = {s_reg.rx[MAXW-2:0], miso_sync};
      end else begin
        s_next.sh   = {s_reg.sh[MAXW-2:0], 1'b0};
        s_next.left = s_reg.left - 6'h01;
        if (s_reg.left == 6'h01) begin
          s_next.busy = 1'b0;
        end
      end
    end else begin
      s_next.div = s_reg.div + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy    = s_reg.busy;
  assign sclk    = s_reg.sclk;
  assign mosi    = s_reg.sh[MAXW-1];
  assign rx_data = s_reg.rx;

endmodule : sspc_shifter
`default_nettype wire

/* sspc_slave_model.sv */
// Behavioural SPI slave, mode 0, active-low select
`timescale 1ns/1ps
`default_nettype none
module sspc_slave_model #(
  parameter logic [31:0] REPLY = 32'hc3a59e71
) (
  // Serial pins
  input  wire logic   sclk,
  input  wire logic   mosi,
  input  wire logic   sel_n,
  output logic        miso,
  // Captured master data
  output logic [31:0] rx_word
);
  logic [31:0] tx_sh = 32'h0;
  logic        last  = 1'b0;
  // Reload on select; nothing is carried across frames
  always @(negedge sel_n) begin
    tx_sh   = REPLY;
    rx_word = 32'h0;
  end
  always @(posedge sclk) if (!sel_n) rx_word = {rx_word[30:0], mosi};
  always @(negedge sclk) if (!sel_n) tx_sh = {tx_sh[30:0], 1'b0};
  // Deselected line shows the inverse of the last bit, never a stale one
  always @* begin
    if (!sel_n) last = tx_sh[31];
    miso = sel_n ? ~last : tx_sh[31];
  end
endmodule : sspc_slave_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the SPI port script control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module testbench;
  import sspc_pkg::*;
  typedef struct {logic [1:0] c; logic [5:0] b; logic [31:0] w; logic [3:0] l;
    logic ee; logic [5:0] eb; logic [3:0] ecs; logic [31:0] er;} sspc_row_t;
  localparam logic [31:0] REPLY = 32'hc3a59e71;
  logic clk = 1'b0, reset = 1'b1, script_start = 1'b0, script_port = 1'b0;
  logic script_end = 1'b0, cmd_valid = 1'b0;
  logic [1:0] cmd_code = 2'h0, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_i;
  logic [5:0] cmd_bits = 6'h00, bits_per_sample;
  logic [31:0] cmd_wdata = 32'h0, cmd_rdata, rx_word;
  logic [3:0] cs_level = 4'h0, cs_o, cs_oe_n;
  logic cmd_ready, cmd_done, port_enabled, miso, sclk_w, mosi_w, sel_n;
  int errors = 0, samples_checked = 0;
  sspc_row_t rows [8];
  // ==========================================================================
  // Pins: clock and data pulled low, selects pulled high when released
  assign sclk_w = sclk_oe_n[0] ? 1'b0 : sclk_o[0];
  assign mosi_w = mosi_oe_n[0] ? 1'b0 : mosi_o[0];
  assign sel_n  = cs_oe_n[0] ? 1'b1 : cs_o[0];
  assign miso_i = {~miso, miso};
  sspc_ctrl sspc_ctrl_inst (.clk(clk), .reset(reset), .script_start(script_start),
    .script_port(script_port), .script_end(script_end), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bits(cmd_bits), .cmd_wdata(cmd_wdata), .cs_level(cs_level),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
    .port_enabled(port_enabled), .bits_per_sample(bits_per_sample), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(miso_i),
    .cs_o(cs_o), .cs_oe_n(cs_oe_n));
  sspc_slave_model #(.REPLY(REPLY)) sspc_slave_model_inst (.sclk(sclk_w),
    .mosi(mosi_w), .sel_n(sel_n), .miso(miso), .rx_word(rx_word));
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  task automatic cmd(input logic [1:0] c, input logic [5:0] b, input logic [31:0] w,
                     input logic [3:0] l);
    int n;
    n = 0;
    @(negedge clk);
    `CHK("ready_idle", 1'b1, cmd_ready)
    cmd_code = c; cmd_bits = b; cmd_wdata = w; cs_level = l; cmd_valid = 1'b1;
    do begin
      @(negedge clk);
      n++;
      if (n == 1) `CHK("ready", 1'b0, cmd_ready)
    end while (cmd_done !== 1'b1 && n < 2000);
    cmd_valid = 1'b0;
    if (n >= 2000) errors++;
    if (c != 2'h3) `CHK("done_cyc", 3, n)
  endtask : cmd
  task automatic pins(input logic [1:0] oe);
    `CHK("sclk_oe_n", oe, sclk_oe_n)
    `CHK("mosi_oe_n", oe, mosi_oe_n)
    `CHK("cs_oe_n", (oe == 2'h3) ? 4'hf : 4'h0, cs_oe_n)
  endtask : pins
  task automatic pulse(input bit s);
    @(negedge clk);
    if (s) script_start = 1'b1; else script_end = 1'b1;
    @(negedge clk);
    script_start = 1'b0; script_end = 1'b0;
    @(negedge clk);
  endtask : pulse
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #1000000;
    errors++;
    results();
  end
  // ==========================================================================
  // Main sequence; select driven low by each row-table transfer and held low until the next enable or the disable
  initial begin
    rows = '{'{2'h1, 6'h00, 32'h0, 4'h0, 1'b1, 6'h08, 4'hf, 32'h0},
             '{2'h2, 6'h0c, 32'h0, 4'h0, 1'b1, 6'h0c, 4'hf, 32'h0},
             '{2'h3, 6'h00, 32'h5a3, 4'he, 1'b1, 6'h0c, 4'he, REPLY >> 20},
             '{2'h2, 6'h03, 32'h0, 4'h0, 1'b1, 6'h04, 4'he, 32'h0},
             '{2'h1, 6'h00, 32'h0, 4'h0, 1'b1, 6'h04, 4'hf, 32'h0},
             '{2'h3, 6'h00, 32'h9, 4'he, 1'b1, 6'h04, 4'he, REPLY >> 28},
             '{2'h2, 6'h3f, 32'h0, 4'h0, 1'b1, 6'h20, 4'he, 32'h0},
             '{2'h0, 6'h00, 32'h0, 4'h0, 1'b0, 6'h20, 4'he, 32'h0}};
    repeat (12) @(negedge clk);
    `CHK("rst_en", 1'b0, port_enabled)
    `CHK("rst_bits", SSPC_BITS_RESET, bits_per_sample)
    pins(2'h3);
    reset = 1'b0;
    pulse(1'b1);
    for (int i = 0; i < 8; i++) begin
      cmd(rows[i].c, rows[i].b, rows[i].w, rows[i].l);
      `CHK("enabled", rows[i].ee, port_enabled)
      `CHK("bits", rows[i].eb, bits_per_sample)
      pins(rows[i].ee ? 2'h2 : 2'h3);
      if (rows[i].ee) `CHK("cs_o", rows[i].ecs, cs_o)
      if (rows[i].c == 2'h3) begin
        `CHK("rdata", rows[i].er, cmd_rdata)
        `CHK("slave_rx", rows[i].w, rx_word & ((32'h1 << rows[i].eb) - 1))
      end
      $display("row %0d done", i);
    end
    pulse(1'b0);
    `CHK("end_bits", SSPC_BITS_RESET, bits_per_sample)
    $display("script end test done");
    script_port = 1'b1;
    pulse(1'b1);
    cmd(2'h2, 6'h05, 32'h0, 4'h0);
    cmd(2'h1, 6'h00, 32'h0, 4'h0);
    pins(2'h1);
    `CHK("sclk_idle", 1'b0, sclk_o[1])
    `CHK("bits5", 6'h05, bits_per_sample)
    cmd(2'h0, 6'h00, 32'h0, 4'h0);
    cmd(2'h3, 6'h00, 32'h3, 4'h5);
    pins(2'h3);
    `CHK("off_en", 1'b0, port_enabled)
    `CHK("cs_off", 4'h5, cs_o)
    pulse(1'b1);
    `CHK("start_bits", SSPC_BITS_RESET, bits_per_sample)
    $display("port select test done");
    // Reset in mid-script must float every pin and drop the width
    cmd(2'h2, 6'h06, 32'h0, 4'h0);
    cmd(2'h1, 6'h00, 32'h0, 4'h0);
    @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    `CHK("mid_en", 1'b0, port_enabled)
    `CHK("mid_bits", SSPC_BITS_RESET, bits_per_sample)
    pins(2'h3);
    reset = 1'b0;
    @(negedge clk);
    `CHK("mid_ready", 1'b1, cmd_ready)
    `CHK("mid_off", 1'b0, port_enabled)
    $display("mid-run reset test done");
    results();
  end
endmodule : testbench
`default_nettype wire
